/* verilog/gpl_port.sv */
/*
 * 16-pin general-purpose I/O port: direction, output type, speed, pull and
 * alternate-function selection per pin, output data with atomic set/clear,
 * input sampling and a key-sequence configuration lock.
 * Assumes an AHB-lite bus on clk, pads outside resolving oe/out, and
 * oscillator enables from clock control logic on the same clock.
 */
//
// Contract
// - sixteen pins, direction picks in/out/alt/analog
// - speed outputs follow speed bits always
// - pulls from pull field, none in analog
// - output data read/write, input data read-only
// - set/clear word sets low, clears high
// - zero bits no effect, set beats clear
// - set/clear one-shot, output stays directly writable
// - lock bit freezes that pin's configuration fields
// - completed lock holds until reset
// - lock sequence accepted only on word writes
// - one alt selection routes both directions
// - input mode: driver off, sample every cycle
// - output: zero low, one high or released
// - output reads written value, input reads pin
// - alternate mode: peripheral drives enable and data
// - analog: driver, pulls off, input reads zero
// - slow oscillator takes pins 14 and 15
// - fast oscillator takes pins 0 and 1
// - power-down returns pins 14, 15 to analog
// - reset leaves all pins floating inputs
// - direction codes 00 in, 01 out, 10 alt, 11 analog
module gpl_port
    import gpl_pkg::*;
#(
    parameter logic [1:0] PORT_KIND = GPL_KIND_PLAIN
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // pads
    input wire logic [GPL_PINS-1:0] pin_in,
    output logic [GPL_PINS-1:0] pin_out,
    output logic [GPL_PINS-1:0] pin_oe,
    output logic [GPL_PINS-1:0] pull_up_en,
    output logic [GPL_PINS-1:0] pull_down_en,
    output logic [GPL_PINS-1:0] input_buf_en,
    output logic [2*GPL_PINS-1:0] speed_ctrl,
    // alternate-function channels, pin i channel k at bit i*16+k
    input wire logic [GPL_PINS*GPL_AFS-1:0] af_tx_data,
    input wire logic [GPL_PINS*GPL_AFS-1:0] af_tx_en,
    output logic [GPL_PINS*GPL_AFS-1:0] af_rx_data,
    // oscillator and power sharing
    input wire logic slow_osc_enable,
    input wire logic fast_osc_enable,
    input wire logic core_power_down,
    output logic slow_crystal_active,
    output logic fast_crystal_active
);

    logic [31:0] dir_reg, speed_reg, pull_reg, aflo_reg, afhi_reg;
    logic [15:0] otype_reg, odr_reg, idr_reg, lk_reg, seq_mask_reg;
    logic [15:0] sync1_reg, sync2_reg;
    logic pd_sync1_reg, pd_sync2_reg;
    gpl_lock_e lock_state_reg;
    logic [GPL_AW-1:0] acc_addr_reg, reg_ofs;
    logic [2:0] acc_size_reg;
    logic wr_pulse_reg, rd_phase_reg;
    logic [31:0] rdata_reg;
    logic [15:0] analog_mask, osc_mask;
    logic [GPL_PINS-1:0] oe_next, out_next, pu_next, pdn_next;
    logic [GPL_PINS*GPL_AFS-1:0] rx_next;
    logic take, lck_wr, lck_rd, word_acc, key_bit;
    logic [31:0] wmask, m2, m4lo, m4hi, m1;
    logic [15:0] bsc_set, bsc_clr;

    function automatic logic [31:0] expand2(input logic [15:0] m);
        logic [31:0] r;
        r = '0;
        for (int i = 0; i < 16; i++) begin
            r[2*i +: 2] = {2{m[i]}};
        end
        return r;
    endfunction

    function automatic logic [31:0] expand4(input logic [7:0] m);
        logic [31:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[4*i +: 4] = {4{m[i]}};
        end
        return r;
    endfunction

    function automatic logic [31:0] lane_mask(input logic [2:0] sz, input logic [1:0] a);
        case (sz)
            GPL_SIZE_BYTE: lane_mask = 32'h0000_00ff << {a, 3'h0};
            GPL_SIZE_HALF: lane_mask = 32'h0000_ffff << {a[1], 4'h0};
            default: lane_mask = 32'hffff_ffff;
        endcase
    endfunction

    // only unlocked pins in enabled byte lanes take the new value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
                                          input logic [31:0] wm, input logic [31:0] lm);
        logic [31:0] en;
        en = wm & ~lm;
        return (old & ~en) | (nv & en);
    endfunction

    // bus: writes take no wait, reads one wait so that a write just before is seen
    assign take = hsel & hready & htrans[1];
    assign hreadyout = ~rd_phase_reg;
    assign hresp = 1'b0;
    assign hrdata = rdata_reg;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            acc_addr_reg <= '0;
            acc_size_reg <= GPL_SIZE_WORD;
            wr_pulse_reg <= 1'b0;
            rd_phase_reg <= 1'b0;
        end else begin
            wr_pulse_reg <= take & hwrite;
            rd_phase_reg <= take & ~hwrite;
            if (take) begin
                acc_addr_reg <= haddr[GPL_AW-1:0];
                acc_size_reg <= hsize;
            end
        end
    end

    assign wmask = lane_mask(acc_size_reg, acc_addr_reg[1:0]);
    assign word_acc = (acc_size_reg == GPL_SIZE_WORD);
    // registers decode on the word; haddr[1:0] only picks the byte lanes
    assign reg_ofs = {acc_addr_reg[GPL_AW-1:2], 2'h0};
    assign lck_wr = wr_pulse_reg & (reg_ofs == GPL_OFS_LOCK);
    assign lck_rd = rd_phase_reg & (reg_ofs == GPL_OFS_LOCK);
    assign key_bit = hwdata[GPL_LOCK_KEY_BIT];
    assign m2 = expand2(lk_reg);
    assign m4lo = expand4(lk_reg[7:0]);
    assign m4hi = expand4(lk_reg[15:8]);
    assign m1 = {16'h0000, lk_reg};

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_reg <= '0;
        end else if (rd_phase_reg) begin
            case (reg_ofs)
                GPL_OFS_DIR: rdata_reg <= dir_reg;
                GPL_OFS_OTYPE: rdata_reg <= {16'h0000, otype_reg};
                GPL_OFS_SPEED: rdata_reg <= speed_reg;
                GPL_OFS_PULL: rdata_reg <= pull_reg;
                GPL_OFS_IN: rdata_reg <= {16'h0000, idr_reg};
                GPL_OFS_OUT: rdata_reg <= {16'h0000, odr_reg};
                GPL_OFS_LOCK: rdata_reg <= {15'h0000, lock_state_reg == GPL_LK_DONE, lk_reg};
                GPL_OFS_AFLO: rdata_reg <= aflo_reg;
                GPL_OFS_AFHI: rdata_reg <= afhi_reg;
                default: rdata_reg <= '0;
            endcase
        end
    end

    // configuration registers; locked pins ignore writes
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dir_reg <= GPL_CFG_RESET;
            otype_reg <= GPL_CFG_RESET[15:0];
            speed_reg <= GPL_CFG_RESET;
            pull_reg <= GPL_CFG_RESET;
            aflo_reg <= GPL_CFG_RESET;
            afhi_reg <= GPL_CFG_RESET;
        end else if (wr_pulse_reg) begin
            case (reg_ofs)
                GPL_OFS_DIR: dir_reg <= merge(dir_reg, hwdata, wmask, m2);
                GPL_OFS_OTYPE: otype_reg <= 16'(merge({16'h0000, otype_reg}, hwdata, wmask, m1));
                GPL_OFS_SPEED: speed_reg <= merge(speed_reg, hwdata, wmask, m2);
                GPL_OFS_PULL: pull_reg <= merge(pull_reg, hwdata, wmask, m2);
                GPL_OFS_AFLO: aflo_reg <= merge(aflo_reg, hwdata, wmask, m4lo);
                GPL_OFS_AFHI: afhi_reg <= merge(afhi_reg, hwdata, wmask, m4hi);
                default: dir_reg <= dir_reg;
            endcase
        end
    end

    // set/clear acts once per write and shares the lanes of the bus access
    assign bsc_set = hwdata[15:0] & wmask[15:0];
    assign bsc_clr = hwdata[31:16] & wmask[31:16];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            odr_reg <= GPL_DATA_RESET;
        end else if (wr_pulse_reg && reg_ofs == GPL_OFS_OUT) begin
            odr_reg <= (odr_reg & ~wmask[15:0]) | (hwdata[15:0] & wmask[15:0]);
        end else if (wr_pulse_reg && reg_ofs == GPL_OFS_BSC) begin
            odr_reg <= (odr_reg & ~bsc_clr) | bsc_set;
        end
    end

    // lock sequence; a wrong or narrow lock write restarts it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lock_state_reg <= GPL_LK_IDLE;
            seq_mask_reg <= GPL_DATA_RESET;
            lk_reg <= GPL_DATA_RESET;
        end else begin
            case (lock_state_reg)
                GPL_LK_IDLE: begin
                    if (lck_wr && word_acc && key_bit) begin
                        lock_state_reg <= GPL_LK_ONE;
                        seq_mask_reg <= hwdata[15:0];
                    end
                end
                GPL_LK_ONE: begin
                    if (lck_wr) begin
                        lock_state_reg <= (word_acc && !key_bit && hwdata[15:0] == seq_mask_reg)
                                          ? GPL_LK_ZERO : GPL_LK_IDLE;
                    end
                end
                GPL_LK_ZERO: begin
                    if (lck_wr) begin
                        lock_state_reg <= (word_acc && key_bit && hwdata[15:0] == seq_mask_reg)
                                          ? GPL_LK_AGAIN : GPL_LK_IDLE;
                    end
                end
                GPL_LK_AGAIN: begin
                    if (lck_wr) begin
                        lock_state_reg <= GPL_LK_IDLE;
                    end else if (lck_rd) begin
                        lock_state_reg <= GPL_LK_DONE;
                        lk_reg <= seq_mask_reg;
                    end
                end
                GPL_LK_DONE: lock_state_reg <= GPL_LK_DONE;
                default: lock_state_reg <= GPL_LK_IDLE;
            endcase
        end
    end

    // pin and power-down synchronisers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            pd_sync1_reg <= 1'b0;
            pd_sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            pd_sync1_reg <= core_power_down;
            pd_sync2_reg <= pd_sync1_reg;
        end
    end

    // oscillator ownership overrides the pin configuration
    always_comb begin
        osc_mask = '0;
        if (PORT_KIND == GPL_KIND_SLOW_OSC && (slow_osc_enable || pd_sync2_reg)) begin
            osc_mask = GPL_SLOW_OSC_PINS;
        end
        if (PORT_KIND == GPL_KIND_FAST_OSC && fast_osc_enable) begin
            osc_mask = GPL_FAST_OSC_PINS;
        end
    end

    always_comb begin
        logic [1:0] mode;
        logic [3:0] sel;
        logic [1:0] pl;
        int idx;
        mode = GPL_MODE_IN;
        sel = '0;
        pl = '0;
        idx = 0;
        analog_mask = '0;
        oe_next = '0;
        out_next = '0;
        pu_next = '0;
        pdn_next = '0;
        rx_next = '0;
        for (int i = 0; i < GPL_PINS; i++) begin
            mode = dir_reg[2*i +: 2];
            sel = (i < 8) ? aflo_reg[4*(i%8) +: 4] : afhi_reg[4*(i%8) +: 4];
            pl = pull_reg[2*i +: 2];
            idx = i * GPL_AFS + int'(sel);
            analog_mask[i] = (mode == GPL_MODE_ANA) | osc_mask[i];
            if (!analog_mask[i]) begin
                pu_next[i] = (pl == GPL_PULL_UP);
                pdn_next[i] = (pl == GPL_PULL_DOWN);
                if (mode == GPL_MODE_OUT) begin
                    oe_next[i] = otype_reg[i] ? ~odr_reg[i] : 1'b1;
                    out_next[i] = odr_reg[i];
                end else if (mode == GPL_MODE_ALT) begin
                    oe_next[i] = af_tx_en[idx] & (otype_reg[i] ? ~af_tx_data[idx] : 1'b1);
                    out_next[i] = af_tx_data[idx];
                    rx_next[idx] = sync2_reg[i];
                end
            end
        end
    end

    // pad drive and input capture; input mode leaves oe_next low
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_oe <= '0;
            pin_out <= '0;
            pull_up_en <= '0;
            pull_down_en <= '0;
            input_buf_en <= '0;
            af_rx_data <= '0;
            idr_reg <= GPL_DATA_RESET;
            slow_crystal_active <= 1'b0;
            fast_crystal_active <= 1'b0;
        end else begin
            pin_oe <= oe_next;
            // open-drain never drives high, so its data line rests low
            pin_out <= out_next & ~otype_reg;
            pull_up_en <= pu_next;
            pull_down_en <= pdn_next;
            input_buf_en <= ~analog_mask;
            af_rx_data <= rx_next;
            idr_reg <= sync2_reg & ~analog_mask;
            slow_crystal_active <= (PORT_KIND == GPL_KIND_SLOW_OSC) & slow_osc_enable;
            fast_crystal_active <= (PORT_KIND == GPL_KIND_FAST_OSC) & fast_osc_enable;
        end
    end

    assign speed_ctrl = speed_reg;

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    set_beats_clear_a: assert property (
        wr_pulse_reg && reg_ofs == GPL_OFS_BSC |=>
        ((odr_reg & $past(bsc_set)) == $past(bsc_set)) &&
        ((odr_reg & $past(bsc_clr) & ~$past(bsc_set)) == 16'h0000) &&
        ((odr_reg ^ $past(odr_reg)) & ~($past(bsc_set) | $past(bsc_clr))) == 16'h0000)
        else $error("set/clear write gave wrong output data");
    lock_freeze_cfg_a: assert property (
        lock_state_reg == GPL_LK_DONE |=>
        (((dir_reg ^ $past(dir_reg)) & m2) == 32'h0) &&
        (((aflo_reg ^ $past(aflo_reg)) & m4lo) == 32'h0) &&
        (((otype_reg ^ $past(otype_reg)) & lk_reg) == 16'h0))
        else $error("locked pin configuration changed");
    lock_sticky_a: assert property (
        lock_state_reg == GPL_LK_DONE |=> lock_state_reg == GPL_LK_DONE && $stable(lk_reg))
        else $error("lock released before reset");
    lock_word_only_a: assert property (
        lck_wr && !word_acc && lock_state_reg != GPL_LK_DONE |=> lock_state_reg == GPL_LK_IDLE)
        else $error("narrow lock write did not restart sequence");
    lock_complete_a: assert property (
        lock_state_reg == GPL_LK_AGAIN && lck_rd |=>
        lock_state_reg == GPL_LK_DONE && lk_reg == $past(seq_mask_reg))
        else $error("lock read did not complete sequence");
    analog_reads_zero_a: assert property (
        !$past(reset) |=>
        (idr_reg & $past(analog_mask)) == 16'h0000 && !input_buf_en[0] == $past(analog_mask[0]))
        else $error("analog pin read nonzero");
    input_drv_off_a: assert property (
        dir_reg[1:0] == GPL_MODE_IN |=> !pin_oe[0])
        else $error("input pin driven");
    push_pull_a: assert property (
        dir_reg[1:0] == GPL_MODE_OUT && !otype_reg[0] && !analog_mask[0] |=>
        pin_oe[0] && pin_out[0] == $past(odr_reg[0]))
        else $error("push-pull drive wrong");
    open_drain_a: assert property (
        dir_reg[1:0] == GPL_MODE_OUT && otype_reg[0] && !analog_mask[0] |=>
        pin_oe[0] == !$past(odr_reg[0]) && !pin_out[0])
        else $error("open-drain drive wrong");
    analog_pull_off_a: assert property (
        analog_mask[0] |=> !pull_up_en[0] && !pull_down_en[0] && !pin_oe[0])
        else $error("analog pin pulled or driven");
    read_wait_a: assert property (
        take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    lock_done_c: cover property (lock_state_reg == GPL_LK_AGAIN && lck_rd);
    set_clear_both_c: cover property (wr_pulse_reg && reg_ofs == GPL_OFS_BSC &&
                                      (bsc_set & bsc_clr) != 16'h0000);
    alt_drive_c: cover property (dir_reg[1:0] == GPL_MODE_ALT && pin_oe[0]);

endmodule

/* verilog/gpl_pkg.sv */
/*
 * Shared constants for the 16-pin I/O port with configuration lock:
 * register offsets, mode and pull encodings, lock key position, bus sizes.
 * Assumes a 32-bit AHB-lite style bus with word-aligned register words.
 */
package gpl_pkg;

    localparam int GPL_PINS = 16;
    localparam int GPL_AFS = 16;
    localparam int GPL_AW = 10;

    // register byte offsets
    localparam logic [GPL_AW-1:0] GPL_OFS_DIR = 10'h000;
    localparam logic [GPL_AW-1:0] GPL_OFS_OTYPE = 10'h004;
    localparam logic [GPL_AW-1:0] GPL_OFS_SPEED = 10'h008;
    localparam logic [GPL_AW-1:0] GPL_OFS_PULL = 10'h00c;
    localparam logic [GPL_AW-1:0] GPL_OFS_IN = 10'h010;
    localparam logic [GPL_AW-1:0] GPL_OFS_OUT = 10'h014;
    localparam logic [GPL_AW-1:0] GPL_OFS_BSC = 10'h018;
    localparam logic [GPL_AW-1:0] GPL_OFS_LOCK = 10'h01c;
    localparam logic [GPL_AW-1:0] GPL_OFS_AFLO = 10'h020;
    localparam logic [GPL_AW-1:0] GPL_OFS_AFHI = 10'h024;

    localparam logic [31:0] GPL_CFG_RESET = 32'h0000_0000;
    localparam logic [15:0] GPL_DATA_RESET = 16'h0000;

    // per-pin direction field
    localparam logic [1:0] GPL_MODE_IN = 2'h0;
    localparam logic [1:0] GPL_MODE_OUT = 2'h1;
    localparam logic [1:0] GPL_MODE_ALT = 2'h2;
    localparam logic [1:0] GPL_MODE_ANA = 2'h3;

    // per-pin pull field, 2'h3 is reserved and selects no pull
    localparam logic [1:0] GPL_PULL_UP = 2'h1;
    localparam logic [1:0] GPL_PULL_DOWN = 2'h2;

    localparam int GPL_LOCK_KEY_BIT = 16;
    localparam int GPL_HALF = 16;

    // bus transfer sizes
    localparam logic [2:0] GPL_SIZE_BYTE = 3'h0;
    localparam logic [2:0] GPL_SIZE_HALF = 3'h1;
    localparam logic [2:0] GPL_SIZE_WORD = 3'h2;

    // which pins a port shares with the crystal oscillators
    localparam logic [1:0] GPL_KIND_PLAIN = 2'h0;
    localparam logic [1:0] GPL_KIND_SLOW_OSC = 2'h1;
    localparam logic [1:0] GPL_KIND_FAST_OSC = 2'h2;
    localparam logic [15:0] GPL_SLOW_OSC_PINS = 16'hc000;
    localparam logic [15:0] GPL_FAST_OSC_PINS = 16'h0003;

    typedef enum logic [4:0] {
        GPL_LK_IDLE = 5'b00001,
        GPL_LK_ONE = 5'b00010,
        GPL_LK_ZERO = 5'b00100,
        GPL_LK_AGAIN = 5'b01000,
        GPL_LK_DONE = 5'b10000
    } gpl_lock_e;

endpackage

/* testbench/gpl_pad_model.sv */
/*
 * Pad-side model for the I/O port: resolves each pin from the port's driver,
 * the weak pulls and an optional external source.
 * Assumes the testbench chooses which pins an outside source drives.
 */
module gpl_pad_model
    import gpl_pkg::*;
(
    // clock
    input wire logic clk,
    // port side
    input wire logic [GPL_PINS-1:0] pin_out,
    input wire logic [GPL_PINS-1:0] pin_oe,
    input wire logic [GPL_PINS-1:0] pull_up_en,
    input wire logic [GPL_PINS-1:0] pull_down_en,
    // outside source
    input wire logic [GPL_PINS-1:0] ext_en,
    input wire logic [GPL_PINS-1:0] ext_val,
    output logic [GPL_PINS-1:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // an undriven, unpulled pin wanders so a stale level cannot pass for data
    logic [GPL_PINS-1:0] float_reg = 16'h0000;

    always_ff @(posedge clk) begin
        float_reg <= ~float_reg;
    end

    // a released open-drain pin falls back to pull or outside level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val)
        | (~ext_en & (pull_up_en | (~pull_down_en & float_reg)))));
endmodule

/* testbench/testbench.sv */
/*
 * Self-checking bench for the I/O port: register access, pad behaviour,
 * set/clear, lock sequence, alternate functions and crystal sharing.
 * Assumes the port is built as the slow-crystal port on one clock.
 */
module testbench import gpl_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0, hwrite = 1'b0, hready, hreadyout;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic [15:0] pin_in, pin_out, pin_oe, pull_up_en, pull_down_en, input_buf_en;
    logic [15:0] ext_en = 16'h0000, ext_val = 16'h0000;
    logic [31:0] speed_ctrl;
    logic [255:0] af_tx_data = 256'h0, af_tx_en = 256'h1, af_rx_data;
    logic slow_osc_enable = 1'b0, core_power_down = 1'b0, slow_crystal_active;
    logic fast_osc_enable = 1'b0, fast_crystal_active;
    int n_fail = 0;
    int checks = 0;

    always #4 clk = ~clk;
    assign hready = hreadyout;

    gpl_port #(.PORT_KIND(GPL_KIND_SLOW_OSC)) i_dut (.clk(clk), .reset(reset), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
        .pull_down_en(pull_down_en), .input_buf_en(input_buf_en), .speed_ctrl(speed_ctrl),
        .af_tx_data(af_tx_data), .af_tx_en(af_tx_en), .af_rx_data(af_rx_data),
        .slow_osc_enable(slow_osc_enable), .fast_osc_enable(fast_osc_enable),
        .core_power_down(core_power_down), .slow_crystal_active(slow_crystal_active),
        .fast_crystal_active(fast_crystal_active));

    gpl_pad_model i_pads (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .ext_en(ext_en),
        .ext_val(ext_val), .pin_in(pin_in));

    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // address phase, then hold the data phase until ready is seen high
    task automatic bus(input logic wr, input logic [9:0] a, input logic [2:0] s,
        input logic [31:0] d);
        logic r;
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {22'h0, a};
        hsize <= s;
        @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(negedge clk);
            r = hreadyout;
            q = hrdata;
            @(posedge clk);
        end while (r !== 1'b1);
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        bus(1'b1, a, GPL_SIZE_WORD, d);
    endtask

    task automatic rdc(input string n, input logic [9:0] a, input logic [31:0] e);
        bus(1'b0, a, GPL_SIZE_WORD, 32'h0);
        chk(n, q, e);
    endtask

    // pads answer within three edges; sample away from the clock edge
    task automatic settle();
        repeat (5) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic t_reset();
        for (int a = 0; a < 10'h28; a += 4) begin
            if (a != 10'h10) rdc("reg", a[9:0], 32'h0);
        end
        chk("oe", pin_oe, 16'h0);
        chk("pull", pull_up_en | pull_down_en, 16'h0);
        wr(10'h028, 32'hffff_ffff);
        rdc("unmapped", 10'h028, 32'h0);
    endtask

    task automatic t_modes();
        wr(GPL_OFS_OUT, 32'h1);
        wr(GPL_OFS_PULL, 32'h1);
        for (int m = 0; m < 4; m++) begin
            wr(GPL_OFS_DIR, m);
            settle();
            chk("oe", pin_oe[0], m == 1 || m == 2);
            if (m == 1 || m == 2) chk("out", pin_out[0], m == 1);
            chk("pull", pull_up_en[0], m != 3);
            chk("inbuf", input_buf_en[0], m != 3);
            bus(1'b0, GPL_OFS_IN, GPL_SIZE_WORD, 32'h0);
            chk("in", q[0], m < 2);
        end
        wr(GPL_OFS_OTYPE, 32'h1);
        wr(GPL_OFS_DIR, 32'h1);
        settle();
        chk("od", pin_oe[0], 1'b0);
    endtask

    task automatic t_bsc();
        wr(GPL_OFS_OUT, 32'h00f0);
        wr(GPL_OFS_BSC, 32'h0010_0011);
        rdc("set", GPL_OFS_OUT, 32'h00f1);
        wr(GPL_OFS_BSC, 32'h00c0_0000);
        rdc("clear", GPL_OFS_OUT, 32'h0031);
        rdc("bsc", GPL_OFS_BSC, 32'h0);
        wr(GPL_OFS_OUT, 32'h1234);
        bus(1'b1, GPL_OFS_OUT + 10'h1, GPL_SIZE_BYTE, 32'h0000_ab00);
        rdc("direct", GPL_OFS_OUT, 32'hab34);
        wr(GPL_OFS_SPEED, 32'ha5a5_5a5a);
        settle();
        chk("speed", speed_ctrl, 32'ha5a5_5a5a);
    endtask

    task automatic t_input();
        wr(GPL_OFS_DIR, 32'h0);
        wr(GPL_OFS_PULL, 32'h0);
        @(posedge clk);
        ext_en <= 16'hffff;
        ext_val <= 16'h5a3c;
        settle();
        wr(GPL_OFS_IN, 32'hffff);
        rdc("in", GPL_OFS_IN, 32'h5a3c);
        wr(GPL_OFS_DIR, 32'h0000_ffff);
        settle();
        rdc("analog", GPL_OFS_IN, 32'h5a00);
    endtask

    task automatic t_af();
        wr(GPL_OFS_AFLO, 32'h0000_0500);
        wr(GPL_OFS_DIR, 32'h0000_0020);
        settle();
        chk("rx", af_rx_data[47:32], 16'h0020);
        @(posedge clk);
        af_tx_en[37] <= 1'b1;
        af_tx_data[37] <= 1'b1;
        settle();
        chk("tx", {pin_oe[2], pin_out[2]}, 2'b11);
    endtask

    task automatic t_osc();
        wr(GPL_OFS_DIR, 32'h5000_0000);
        wr(GPL_OFS_PULL, 32'h5000_0000);
        @(posedge clk);
        slow_osc_enable <= 1'b1;
        fast_osc_enable <= 1'b1;
        settle();
        // this port owns only the slow crystal, so the fast enable must not claim it
        chk("xtal", {fast_crystal_active, slow_crystal_active, pin_oe[15:14],
            input_buf_en[15:14]}, 6'h10);
        @(posedge clk);
        slow_osc_enable <= 1'b0;
        fast_osc_enable <= 1'b0;
        settle();
        chk("gpio", pin_oe[15:14], 2'b11);
        @(posedge clk);
        core_power_down <= 1'b1;
        settle();
        chk("down", {pin_oe[15:14], pull_up_en[15:14]}, 4'h0);
        bus(1'b0, GPL_OFS_IN, GPL_SIZE_WORD, 32'h0);
        chk("down_in", q[15:14], 2'h0);
        @(posedge clk);
        core_power_down <= 1'b0;
    endtask

    task automatic t_lock();
        wr(GPL_OFS_DIR, 32'h0);
        wr(GPL_OFS_LOCK, 32'h1_0004);
        bus(1'b1, GPL_OFS_LOCK, GPL_SIZE_HALF, 32'h0000_0004);
        wr(GPL_OFS_LOCK, 32'h1_0004);
        bus(1'b0, GPL_OFS_LOCK, GPL_SIZE_WORD, 32'h0);
        bus(1'b0, GPL_OFS_LOCK, GPL_SIZE_WORD, 32'h0);
        chk("half", q[16], 1'b0);
        wr(GPL_OFS_LOCK, 32'h0);
        // mask held constant through the whole key sequence
        wr(GPL_OFS_LOCK, 32'h1_0003);
        wr(GPL_OFS_LOCK, 32'h0_0003);
        wr(GPL_OFS_LOCK, 32'h1_0003);
        // the completing read still shows the state from before the lock took hold
        rdc("lock_rd", GPL_OFS_LOCK, 32'h0000_0000);
        wr(GPL_OFS_LOCK, 32'h1_ffff);
        rdc("locked", GPL_OFS_LOCK, 32'h1_0003);
        wr(GPL_OFS_DIR, 32'hffff_ffff);
        wr(GPL_OFS_AFLO, 32'hffff_ffff);
        rdc("dir", GPL_OFS_DIR, 32'hffff_fff0);
        rdc("af", GPL_OFS_AFLO, 32'hffff_ff00);
        wr(GPL_OFS_OUT, 32'h5);
        rdc("odr", GPL_OFS_OUT, 32'h5);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rdc("unlock", GPL_OFS_LOCK, 32'h0);
        rdc("dir0", GPL_OFS_DIR, 32'h0);
    endtask

    task automatic end_sim();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        t_reset();
        t_modes();
        t_bsc();
        t_input();
        t_af();
        t_osc();
        t_lock();
        end_sim();
    end

    initial begin
        #100000;
        n_fail++;
        end_sim();
    end
endmodule
